// ---- hw/bsp_pkg.sv ----
// Shared constants and types of the boundary-scan test port.
// Assumes the pin counts below match the parallel pins of the device.
package bsp_pkg;

    // Pin groups covered by the chain
    localparam int PIN_IN_W = 8;
    localparam int PIN_OUT_W = 8;
    localparam int CLK_IN_W = 4;
    localparam int TRI_N = 4;
    localparam int TRI_W = 2 * TRI_N;
    localparam int BSR_LEN = TRI_W + PIN_IN_W + CLK_IN_W + PIN_OUT_W;

    // Instruction register
    localparam int IR_LEN = 4;
    localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

    // Identification register; the code value is arbitrary
    localparam int ID_LEN = 32;
    localparam logic [ID_LEN-1:0] ID_CODE = 32'h1234_5001;

    // Consecutive mode-select highs that always reach the reset state
    localparam int TMS_RESET_CYCLES = 5;

    // Three-level select encodings in the chain
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_MID = 2'h2;
    localparam logic [1:0] TRI_HIGH = 2'h3;

    typedef enum logic [3:0] {
        tap_reset,
        tap_idle,
        tap_sel_dr,
        tap_cap_dr,
        tap_shift_dr,
        tap_exit1_dr,
        tap_pause_dr,
        tap_exit2_dr,
        tap_upd_dr,
        tap_sel_ir,
        tap_cap_ir,
        tap_shift_ir,
        tap_exit1_ir,
        tap_pause_ir,
        tap_exit2_ir,
        tap_upd_ir
    } bsp_tap_state_type;

endpackage

// ---- hw/bsp_tap_fsm.sv ----
// Test access port controller state machine on the test clock.
// Assumes mode select is driven from the falling test clock edge.
`timescale 1ns/1ns
`default_nettype none
module bsp_tap_fsm (
    // Test clock and reset
    input wire logic tck,
    input wire logic trst_n,
    // Mode select
    input wire logic tms,
    // Controller state
    output var bsp_pkg::bsp_tap_state_type state_q
);
    import bsp_pkg::*;

    bsp_tap_state_type state_d;
    logic [2:0] tms_ones_q;

    always_comb
    begin
        state_d = tap_reset;
        case (state_q)
            tap_reset: state_d = tms ? tap_reset : tap_idle;
            tap_idle: state_d = tms ? tap_sel_dr : tap_idle;
            tap_sel_dr: state_d = tms ? tap_sel_ir : tap_cap_dr;
            tap_cap_dr: state_d = tms ? tap_exit1_dr : tap_shift_dr;
            tap_shift_dr: state_d = tms ? tap_exit1_dr : tap_shift_dr;
            tap_exit1_dr: state_d = tms ? tap_upd_dr : tap_pause_dr;
            tap_pause_dr: state_d = tms ? tap_exit2_dr : tap_pause_dr;
            tap_exit2_dr: state_d = tms ? tap_upd_dr : tap_shift_dr;
            tap_upd_dr: state_d = tms ? tap_sel_dr : tap_idle;
            tap_sel_ir: state_d = tms ? tap_reset : tap_cap_ir;
            tap_cap_ir: state_d = tms ? tap_exit1_ir : tap_shift_ir;
            tap_shift_ir: state_d = tms ? tap_exit1_ir : tap_shift_ir;
            tap_exit1_ir: state_d = tms ? tap_upd_ir : tap_pause_ir;
            tap_pause_ir: state_d = tms ? tap_exit2_ir : tap_pause_ir;
            tap_exit2_ir: state_d = tms ? tap_upd_ir : tap_shift_ir;
            tap_upd_ir: state_d = tms ? tap_sel_dr : tap_idle;
            default: state_d = tap_reset;
        endcase
    end

    // Test reset works without the test clock
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            state_q <= tap_reset;
        else
            state_q <= state_d;
    end

    // Saturating count of consecutive mode-select highs
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            tms_ones_q <= 3'h0;
        else if (!tms)
            tms_ones_q <= 3'h0;
        else if (tms_ones_q != 3'h7)
            tms_ones_q <= tms_ones_q + 3'h1;
    end

    a_trst_reset: assert property (@(posedge tck) !trst_n |-> state_q == tap_reset)
        else $error("test reset low but controller not in reset");

    a_tms_five: assert property (@(posedge tck) disable iff (!trst_n)
        (tms_ones_q >= 3'(TMS_RESET_CYCLES)) |-> state_q == tap_reset)
        else $error("five mode-select highs did not reach reset");

    a_reset_exit: assert property (@(posedge tck) disable iff (!trst_n)
        (state_q == tap_reset && !tms) |=> state_q == tap_idle)
        else $error("reset state not left for idle");

    c_tms_reset: cover property (@(posedge tck) disable iff (!trst_n)
        state_q == tap_shift_dr ##1 tms [*5] ##1 state_q == tap_reset);

endmodule
`default_nettype wire

// ---- hw/bsp_test_port.sv ----
// Boundary-scan test port: controller, instruction, identification,
// bypass and boundary registers, and the output cells of the mission pins.
// Assumes the test clock is unrelated to ref_clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module bsp_test_port (
    // Mission clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Test port pins
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_q,
    output logic tdo_oe_q,
    // Parallel and clock input pins
    input wire logic [bsp_pkg::PIN_IN_W-1:0] par_in,
    input wire logic [bsp_pkg::CLK_IN_W-1:0] clock_input,
    // Three-level selects: per pin {above low threshold, above high threshold}
    input wire logic [bsp_pkg::TRI_W-1:0] tri_level,
    // Parallel outputs: mission value in, pin value out
    input wire logic [bsp_pkg::PIN_OUT_W-1:0] core_out,
    output logic [bsp_pkg::PIN_OUT_W-1:0] pin_out_q
);
    import bsp_pkg::*;

    function automatic logic [1:0] tri_encode(input logic [1:0] lvl);
        // The impossible comparator pair 01 reads as mid
        tri_encode = {lvl[1] | lvl[0], lvl[1] & lvl[0]};
    endfunction

    bsp_tap_state_type tap_state;
    logic [IR_LEN-1:0] ir_q;
    logic [IR_LEN-1:0] ir_shift_q;
    logic [ID_LEN-1:0] id_q;
    logic byp_q;
    logic [BSR_LEN-1:0] bsr_q;
    logic [PIN_OUT_W-1:0] upd_q;
    logic ext_q;
    // Pin and mission output samplers on the test clock
    logic [PIN_IN_W-1:0] in_s1_q;
    logic [PIN_IN_W-1:0] in_s2_q;
    logic [CLK_IN_W-1:0] clk_s1_q;
    logic [CLK_IN_W-1:0] clk_s2_q;
    logic [TRI_W-1:0] tri_s1_q;
    logic [TRI_W-1:0] tri_s2_q;
    logic [PIN_OUT_W-1:0] core_s1_q;
    logic [PIN_OUT_W-1:0] core_s2_q;
    // Crossings into ref_clk
    logic ext_s1_q;
    logic ext_s2_q;
    logic upd_tgl_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic [PIN_OUT_W-1:0] upd_hold_q;

    bsp_tap_fsm u_tap (
        .tck(tck),
        .trst_n(trst_n),
        .tms(tms),
        .state_q(tap_state)
    );

    wire in_reset = tap_state == tap_reset;
    wire cap_dr = tap_state == tap_cap_dr;
    wire sh_dr = tap_state == tap_shift_dr;
    wire upd_dr = tap_state == tap_upd_dr;
    wire cap_ir = tap_state == tap_cap_ir;
    wire sh_ir = tap_state == tap_shift_ir;
    wire upd_ir = tap_state == tap_upd_ir;

    wire sel_ext = ir_q == IR_EXTEST;
    wire sel_bsr = sel_ext || ir_q == IR_SAMPLE;
    wire sel_id = ir_q == IR_IDCODE;
    wire sel_byp = !(sel_bsr || sel_id);

    // Chain order from the data input side: outputs, clocks, inputs, selects
    wire [TRI_W-1:0] tri_enc;
    genvar gi;
    generate
        for (gi = 0; gi < TRI_N; gi++)
        begin : g_tri
            assign tri_enc[2*gi+1:2*gi] = tri_encode(tri_s2_q[2*gi+1:2*gi]);
        end
    endgenerate
    // Serial line pins are absent from the chain
    wire [BSR_LEN-1:0] cap_vec = {core_s2_q, clk_s2_q, in_s2_q, tri_enc};

    wire tdo_mux = sh_ir ? ir_shift_q[0] :
                   sel_bsr ? bsr_q[0] :
                   sel_id ? id_q[0] : byp_q;

    // Two-stage samplers of asynchronous pins and mission outputs
    always_ff @(posedge tck)
    begin
        in_s1_q <= par_in;
        in_s2_q <= in_s1_q;
        clk_s1_q <= clock_input;
        clk_s2_q <= clk_s1_q;
        tri_s1_q <= tri_level;
        tri_s2_q <= tri_s1_q;
        core_s1_q <= core_out;
        core_s2_q <= core_s1_q;
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            ir_shift_q <= IR_CAPTURE;
        else if (cap_ir)
            ir_shift_q <= IR_CAPTURE;
        else if (sh_ir)
            ir_shift_q <= {tdi, ir_shift_q[IR_LEN-1:1]};
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            ir_q <= IR_IDCODE;
        else if (in_reset)
            ir_q <= IR_IDCODE;
        else if (upd_ir)
            ir_q <= ir_shift_q;
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            id_q <= ID_CODE;
        else if (cap_dr && sel_id)
            id_q <= ID_CODE;
        else if (sh_dr && sel_id)
            id_q <= {tdi, id_q[ID_LEN-1:1]};
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            byp_q <= 1'b0;
        else if (cap_dr && sel_byp)
            byp_q <= 1'b0;
        else if (sh_dr && sel_byp)
            byp_q <= tdi;
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            bsr_q <= '0;
        else if (cap_dr && sel_bsr)
            bsr_q <= cap_vec;
        else if (sh_dr && sel_bsr)
            bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
    end

    // Output cells update on sample too, so a pattern can be preloaded
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            upd_q <= '0;
            upd_tgl_q <= 1'b0;
        end
        else if (upd_dr && sel_bsr)
        begin
            upd_q <= bsr_q[BSR_LEN-1 -: PIN_OUT_W];
            upd_tgl_q <= !upd_tgl_q;
        end
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            ext_q <= 1'b0;
        else
            ext_q <= sel_ext && !in_reset;
    end

    // Data out changes on the falling test clock edge
    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q <= tdo_mux;
            tdo_oe_q <= sh_ir || sh_dr;
        end
    end

    // The update word is not synchronised, only its toggle; the word is stable when it is taken,
    // so the pins never show a mix of old and new update bits
    always_ff @(posedge ref_clk)
    begin
        tgl_s1_q <= upd_tgl_q;
        tgl_s2_q <= tgl_s1_q;
        tgl_s3_q <= tgl_s2_q;
    end

    wire upd_new = tgl_s2_q != tgl_s3_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            upd_hold_q <= '0;
            pin_out_q <= '0;
        end
        else
        begin
            ext_s1_q <= ext_q;
            ext_s2_q <= ext_s1_q;
            upd_hold_q <= upd_new ? upd_q : upd_hold_q;
            pin_out_q <= ext_s2_q ? upd_hold_q : core_out;
        end
    end

    a_ir_reset_id: assert property (@(posedge tck) disable iff (!trst_n)
        in_reset |=> ir_q == IR_IDCODE && !ext_q)
        else $error("reset state did not select identification");

    a_id_capture: assert property (@(posedge tck) disable iff (!trst_n)
        (cap_dr && sel_id) |=> id_q == ID_CODE)
        else $error("identification code not captured");

    a_bypass_path: assert property (@(posedge tck) disable iff (!trst_n)
        (cap_dr && sel_byp) ##1 sh_dr |=> byp_q == $past(tdi))
        else $error("bypass bit did not follow data input");

    a_other_bypass: assert property (@(posedge tck) disable iff (!trst_n)
        (sh_dr && ir_q != IR_EXTEST && ir_q != IR_SAMPLE && ir_q != IR_IDCODE)
        |-> tdo_mux == byp_q)
        else $error("unsupported instruction did not select bypass");

    a_tri_code: assert property (@(posedge tck) disable iff (!trst_n)
        (tri_s2_q[1:0] == 2'h1) |-> tri_enc[1:0] == TRI_MID)
        else $error("mid select level miscoded");

    a_chain_capture: assert property (@(posedge tck) disable iff (!trst_n)
        (cap_dr && sel_bsr) |=> bsr_q[PIN_OUT_W-1 + TRI_W + PIN_IN_W + CLK_IN_W -: PIN_OUT_W]
        == $past(core_s2_q))
        else $error("output cells did not capture mission values");

    a_transparent: assert property (@(posedge ref_clk) disable iff (rst)
        !ext_s2_q |=> pin_out_q == $past(core_out))
        else $error("pins not transparent outside boundary drive");

    a_extest_drive: assert property (@(posedge ref_clk) disable iff (rst)
        ext_s2_q |=> pin_out_q == $past(upd_hold_q))
        else $error("pins not driven from update cells");

    a_hold_load: assert property (@(posedge ref_clk) disable iff (rst)
        upd_new |=> upd_hold_q == $past(upd_q))
        else $error("update word not taken on its toggle");

    a_reset_mission: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> !ext_s2_q && pin_out_q == '0)
        else $error("functional reset left boundary drive active");

    c_extest: cover property (@(posedge ref_clk) disable iff (rst) ext_s2_q);

    c_id_shift: cover property (@(posedge tck) disable iff (!trst_n)
        (cap_dr && sel_id) ##1 sh_dr [*8]);

    c_ir_load: cover property (@(posedge tck) disable iff (!trst_n)
        upd_ir ##1 ir_q == IR_EXTEST);

endmodule
`default_nettype wire

// ---- bench/bsp_tester.sv ----
// Model of the external boundary-scan test controller.
// Assumes the port samples mode select and data on the rising test clock.
`timescale 1ns/1ns
`default_nettype none
module bsp_tester (
    // Test port pins
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi,
    input wire logic tdo_q,
    input wire logic tdo_oe_q
);
    localparam int HALF = 80;

    // Data out enable seen at the last rising edge, and over the last shift
    logic oe_last;
    logic oe_all;

    initial
    begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        oe_last = 1'b0;
        oe_all = 1'b0;
    end

    // One test clock; the clock rests low outside frames
    task automatic step(input logic m, input logic d, output logic o);
    begin
        tms = m;
        tdi = d;
        #HALF tck = 1'b1;
        o = tdo_q;
        oe_last = tdo_oe_q;
        #HALF tck = 1'b0;
    end
    endtask

    task automatic set_trst(input logic v);
    begin
        #13 trst_n = v;
    end
    endtask

    // Mode select high n times, then one low to rest in idle
    task automatic tms_reset(input int n);
        logic o;
    begin
        #13;
        repeat (n) step(1'b1, tdi, o);
        step(1'b0, tdi, o);
    end
    endtask

    // From idle: shift n bits of IR or DR, LSB first, back to idle
    task automatic scan(input logic ir, input logic [63:0] din, input int n,
                        output logic [63:0] dout);
        logic o;
    begin
        dout = '0;
        oe_all = 1'b1;
        #13;
        step(1'b1, tdi, o);
        if (ir)
            step(1'b1, tdi, o);
        step(1'b0, tdi, o);
        step(1'b0, tdi, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
            oe_all = oe_all & oe_last;
        end
        step(1'b1, ~din[n-1], o);
        step(1'b0, din[n-1], o);
        // Released data line shows no stale value
        tdi = ~tdi;
    end
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the boundary-scan test port.
// Assumes the tester model drives the test pins and rests the clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import bsp_pkg::*;
    logic ref_clk, rst, tck, trst_n, tms, tdi, tdo_q, tdo_oe_q;
    logic [PIN_IN_W-1:0] par_in;
    logic [CLK_IN_W-1:0] clock_input;
    logic [TRI_W-1:0] tri_level;
    logic [PIN_OUT_W-1:0] core_out;
    logic [PIN_OUT_W-1:0] pin_out_q;
    logic [63:0] dout;
    int miscompares;
    int n_checks;

    bsp_test_port u_bsp_test_port (.ref_clk(ref_clk), .rst(rst), .tck(tck),
        .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q),
        .par_in(par_in), .clock_input(clock_input), .tri_level(tri_level),
        .core_out(core_out), .pin_out_q(pin_out_q));
    bsp_tester u_bsp_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    end
    endtask

    task automatic wrap_up();
    begin
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    task automatic t_resets();
    begin
        repeat (12) @(negedge ref_clk);
        check(32'(pin_out_q), 32'h0, "pins in reset");
        rst = 1'b0;
        @(negedge ref_clk);
        core_out = 8'hA5;
        @(negedge ref_clk);
        check(32'(pin_out_q), 32'hA5, "mission path first");
        u_bsp_tester.set_trst(1'b1);
        u_bsp_tester.tms_reset(0);
    end
    endtask

    task automatic t_idcode();
    begin
        u_bsp_tester.scan(1'b0, 64'h0, 32, dout);
        check(dout[31:0], ID_CODE, "id after test reset");
        check(32'(u_bsp_tester.oe_all), 32'h1, "data out driven while shifting");
        u_bsp_tester.scan(1'b1, 64'(IR_BYPASS), 4, dout);
        check(32'(dout[3:0]), 32'(IR_CAPTURE), "ir capture");
        u_bsp_tester.set_trst(1'b0);
        u_bsp_tester.tms_reset(2);
        check(32'(tdo_oe_q), 32'h0, "data out off in test reset");
        u_bsp_tester.set_trst(1'b1);
        u_bsp_tester.tms_reset(0);
        u_bsp_tester.scan(1'b0, 64'h0, 32, dout);
        check(dout[31:0], ID_CODE, "id after test reset pulse");
        u_bsp_tester.scan(1'b1, 64'(IR_BYPASS), 4, dout);
        u_bsp_tester.tms_reset(5);
        u_bsp_tester.scan(1'b0, 64'h0, 32, dout);
        check(dout[31:0], ID_CODE, "id after five highs");
    end
    endtask

    task automatic t_bypass();
        logic [3:0] codes [4];
    begin
        codes = '{IR_BYPASS, 4'h3, 4'h7, 4'hC};
        foreach (codes[i])
        begin
            u_bsp_tester.scan(1'b1, 64'(codes[i]), 4, dout);
            u_bsp_tester.scan(1'b0, 64'h0B5, 9, dout);
            check(32'(dout[8:0]), 32'h16A, "one bit delay");
        end
    end
    endtask

    task automatic t_sample();
        logic [27:0] exp;
    begin
        // Functional reset again, this time after the test port was reset
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(32'(pin_out_q), 32'h0, "pins in second reset");
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(32'(pin_out_q), 32'(core_out), "mission after second reset");
        for (int k = 0; k < 2; k++)
        begin
            @(negedge ref_clk);
            par_in = k ? 8'hC3 : 8'h3C;
            clock_input = k ? 4'h6 : 4'h9;
            tri_level = k ? 8'h4D : 8'hB2;
            core_out = k ? 8'h1E : 8'hE1;
            exp = k ? {8'h1E, 4'h6, 8'hC3, TRI_MID, TRI_LOW, TRI_HIGH, TRI_MID} :
                      {8'hE1, 4'h9, 8'h3C, TRI_MID, TRI_HIGH, TRI_LOW, TRI_MID};
            u_bsp_tester.scan(1'b1, 64'(IR_SAMPLE), 4, dout);
            u_bsp_tester.scan(1'b0, 64'h1, 29, dout);
            check(32'(dout[27:0]), 32'(exp), "captured pins");
            check(32'(dout[28]), 32'h1, "chain length");
            check(32'(pin_out_q), 32'(core_out), "pins transparent");
        end
    end
    endtask

    task automatic t_extest();
        logic [7:0] v;
    begin
        for (int k = 0; k < 2; k++)
        begin
            v = k ? 8'h96 : 8'h69;
            @(negedge ref_clk);
            core_out = ~v;
            u_bsp_tester.scan(1'b1, 64'(IR_EXTEST), 4, dout);
            u_bsp_tester.scan(1'b0, 64'(v) << 20, 28, dout);
            repeat (6) @(negedge ref_clk);
            check(32'(pin_out_q), 32'(v), "boundary drive");
            check(32'(tdo_oe_q), 32'h0, "data out released");
            if (k == 0)
                u_bsp_tester.set_trst(1'b0);
            else
                u_bsp_tester.tms_reset(5);
            repeat (6) @(negedge ref_clk);
            check(32'(pin_out_q), 32'(core_out), "mission restored");
            u_bsp_tester.set_trst(1'b1);
            u_bsp_tester.tms_reset(0);
        end
    end
    endtask

    initial
    begin
        rst = 1'b1;
        core_out = 8'h5A;
        par_in = '0;
        clock_input = '0;
        tri_level = '0;
        miscompares = 0;
        n_checks = 0;
        t_resets();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        wrap_up();
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
